// file: hdl/irq_enable_defines.svh
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

// ==========================================================
// register map
`define IEN_ADDR_W 12
`define IEN_SET_OFF 12'h000
`define IEN_CLR_OFF 12'h004

// ==========================================================
// field layout and reset
`define IEN_IMPL_MASK 32'h7FFFDFFF
`define IEN_RESET_VAL 32'h00000000
`define IEN_LINES 32

`endif

// file: hdl/irq_enable_pkg.sv
package irq_enable_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_SET = 2'h1,
        SEL_CLR = 2'h3
    } reg_sel_t;

endpackage

// file: hdl/enable_bank_if.sv
`timescale 1ns/1ps

interface enable_bank_if;
    irq_enable_pkg::word_t set_mask;
    irq_enable_pkg::word_t clr_mask;
    irq_enable_pkg::word_t en_state;

    modport ctrl (
        output set_mask,
        output clr_mask,
        input en_state
    );

    modport bank (
        input set_mask,
        input clr_mask,
        output en_state
    );
endinterface

// file: hdl/enable_bank.sv
`timescale 1ns/1ps
`include "irq_enable_defines.svh"

module enable_bank (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // control side
    enable_bank_if.bank bank_if
);

    irq_enable_pkg::word_t en_q;
    irq_enable_pkg::word_t en_d;

    // ==========================================================
    // per-line enable state, shared by set and clear views
    always_comb begin
        en_d = en_q | bank_if.set_mask;
        en_d = en_d & ~bank_if.clr_mask;
        en_d = en_d & `IEN_IMPL_MASK;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_q <= `IEN_RESET_VAL;
        end else begin
            en_q <= en_d;
        end
    end

    assign bank_if.en_state = en_q;

endmodule

// file: hdl/irq_enable_clear_low.sv
`timescale 1ns/1ps
`include "irq_enable_defines.svh"

module irq_enable_clear_low (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [`IEN_ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // interrupt line enables
    output logic [`IEN_LINES-1:0] enable_o
);

    enable_bank_if bank_if ();

    irq_enable_pkg::reg_sel_t sel;
    irq_enable_pkg::word_t rdata_q;
    irq_enable_pkg::word_t rdata_d;
    logic access;
    logic setup;
    logic wr_set;
    logic wr_clr;
    logic rd_hit;
    logic bad_addr;

    // ==========================================================
    // address decode
    function automatic irq_enable_pkg::reg_sel_t decode(input logic [`IEN_ADDR_W-1:0] a);
        if (a == `IEN_SET_OFF) begin
            return irq_enable_pkg::SEL_SET;
        end else if (a == `IEN_CLR_OFF) begin
            return irq_enable_pkg::SEL_CLR;
        end
        return irq_enable_pkg::SEL_NONE;
    endfunction

    // reserved positions are stripped on every path, so no flop ever holds a one there
    function automatic irq_enable_pkg::word_t impl_bits(input irq_enable_pkg::word_t w);
        return w & `IEN_IMPL_MASK;
    endfunction

    // ==========================================================
    // bus phase qualifiers
    assign sel = decode(paddr_i);
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign bad_addr = (sel == irq_enable_pkg::SEL_NONE);
    assign wr_set = access && pwrite_i && (sel == irq_enable_pkg::SEL_SET);
    assign wr_clr = access && pwrite_i && (sel == irq_enable_pkg::SEL_CLR);
    assign rd_hit = setup && !pwrite_i && !bad_addr;

    // zero wait states; read data is latched in setup so it comes from a flop
    assign pready_o = 1'b1;
    assign pslverr_o = access && bad_addr;

    // ==========================================================
    // write strobes toward the shared enable bank
    always_comb begin
        bank_if.set_mask = '0;
        bank_if.clr_mask = '0;
        if (wr_set) begin
            bank_if.set_mask = impl_bits(pwdata_i);
        end
        if (wr_clr) begin
            bank_if.clr_mask = impl_bits(pwdata_i);
        end
    end

    enable_bank enable_bank_i (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .bank_if(bank_if)
    );

    // ==========================================================
    // read path: both views show the same live state
    // latching at setup costs no accuracy, since the bus is the only writer
    always_comb begin
        rdata_d = rdata_q;
        if (setup) begin
            rdata_d = '0;
            if (rd_hit) begin
                rdata_d = impl_bits(bank_if.en_state);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata_o = rdata_q;
    assign enable_o = bank_if.en_state;

    // ==========================================================
    // checks
    clr_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && pwrite_i && sel == irq_enable_pkg::SEL_CLR)
        |=> ((enable_o & $past(pwdata_i)) == 32'h00000000))
        else $error("clear write left a line enabled");

    zero_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && pwrite_i && sel == irq_enable_pkg::SEL_CLR)
        |=> ((enable_o & ~$past(pwdata_i)) == ($past(enable_o) & ~$past(pwdata_i))))
        else $error("zero bit changed an enable");

    read_live_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && !pwrite_i && sel == irq_enable_pkg::SEL_CLR)
        |-> (prdata_o == enable_o))
        else $error("clear view read is not the live state");

    set_shared_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && pwrite_i && sel == irq_enable_pkg::SEL_SET)
        |=> ((enable_o & $past(pwdata_i) & `IEN_IMPL_MASK)
             == ($past(pwdata_i) & `IEN_IMPL_MASK)))
        else $error("set write did not reach shared state");

    view_same_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && !pwrite_i && sel == irq_enable_pkg::SEL_SET)
        |-> (prdata_o == enable_o))
        else $error("set view read differs from state");

    reserved_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        ((enable_o & ~`IEN_IMPL_MASK) == 32'h00000000)
        && ((prdata_o & ~`IEN_IMPL_MASK) == 32'h00000000))
        else $error("reserved bit seen as one");

    idle_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !(access && pwrite_i) |=> $stable(enable_o))
        else $error("enables changed without a write");

    unmapped_err_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && sel == irq_enable_pkg::SEL_NONE)
        |-> (pslverr_o && prdata_o == 32'h00000000) ##1 $stable(enable_o))
        else $error("unmapped access misbehaved");

    // ==========================================================
    // bus answer checks
    pready_high_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        pready_o)
        else $error("slave inserted a wait state");

    mapped_ok_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && !bad_addr) |-> !pslverr_o)
        else $error("error flagged on a mapped register");

    unmapped_wr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && pwrite_i && bad_addr)
        |=> $stable(enable_o))
        else $error("unmapped write changed an enable");

    // ==========================================================
    // enable state checks
    clr_no_rise_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_clr
        |=> ((enable_o & ~$past(enable_o)) == 32'h00000000))
        else $error("clear write raised an enable");

    set_no_fall_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_set
        |=> ((~enable_o & $past(enable_o)) == 32'h00000000))
        else $error("set write dropped an enable");

    set_zero_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        wr_set
        |=> ((enable_o & ~$past(pwdata_i)) == ($past(enable_o) & ~$past(pwdata_i))))
        else $error("zero bit in a set write changed an enable");

    read_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (access && !pwrite_i)
        |=> $stable(enable_o))
        else $error("read changed an enable");

    strobe_clean_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (((bank_if.set_mask | bank_if.clr_mask) & ~`IEN_IMPL_MASK) == 32'h00000000))
        else $error("strobe reached a reserved bit");

    strobe_single_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !((bank_if.set_mask != 32'h00000000) && (bank_if.clr_mask != 32'h00000000)))
        else $error("set and clear strobes in one cycle");

    // reset is asynchronous, so this one runs without a disable clause
    reset_clear_a: assert property (@(posedge clk_sys_i)
        $rose(rst_b_i)
        |-> ((enable_o == 32'h00000000) && (prdata_o == 32'h00000000)))
        else $error("state not cleared by reset");

    // ==========================================================
    // read data checks
    rdata_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        !setup
        |=> $stable(prdata_o))
        else $error("read data moved outside a setup cycle");

    read_latch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        rd_hit
        |=> (prdata_o == $past(enable_o)))
        else $error("read data is not the state at setup");

    miss_read_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (setup && bad_addr)
        |=> (prdata_o == 32'h00000000))
        else $error("unmapped read data not zero");

    write_rd_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        (setup && pwrite_i)
        |=> (prdata_o == 32'h00000000))
        else $error("write cycle left stale read data");

endmodule

// file: bench/tb_irq_enable_clear_low.sv
`timescale 1ns/1ps
`include "irq_enable_defines.svh"

module tb_irq_enable_clear_low;
    // ==========================================================
    // stimulus and model state
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [31:0] enable_o;
    logic [31:0] rd;
    logic er;
    logic [31:0] model = 32'h00000000;
    int bad_count = 0;
    int checks = 0;
    int seed = 24514;

    irq_enable_clear_low irq_enable_clear_low_i (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .enable_o(enable_o)
    );

    initial forever #2.5 clk_sys_i = ~clk_sys_i;

    // ==========================================================
    // tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // waits on pready rather than assuming zero wait states
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            $display("[ERR] pready expected 1 seen %b", pready_o);
            bad_count++;
            test_done();
        end else begin
            rd = prdata_o;
            er = pslverr_o;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        if (a == `IEN_SET_OFF) model = model | (d & `IEN_IMPL_MASK);
        else if (a == `IEN_CLR_OFF) model = model & ~d;
    endtask

    task automatic verify();
        @(posedge clk_sys_i);
        chk("enable", model, enable_o);
        xfer(1'b0, `IEN_SET_OFF, 32'h00000000);
        chk("set_view", model, rd);
        chk("set_slverr", 32'h00000000, {31'h0, er});
        xfer(1'b0, `IEN_CLR_OFF, 32'h00000000);
        chk("clr_view", model, rd);
        chk("clr_slverr", 32'h00000000, {31'h0, er});
    endtask

    // ==========================================================
    // sequence
    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        verify();
        $display("test reset done");
        wr(`IEN_SET_OFF, 32'hFFFFFFFF);
        verify();
        wr(`IEN_CLR_OFF, 32'h00000000);
        verify();
        // walking one shows each bit reaches only its own line
        for (int i = 0; i < 32; i++) begin
            wr(`IEN_SET_OFF, 32'hFFFFFFFF);
            wr(`IEN_CLR_OFF, 32'h00000001 << i);
            verify();
        end
        $display("test walk done");
        for (int i = 0; i < 12; i++) begin
            wr(`IEN_CLR_OFF, $random(seed));
            verify();
            wr(`IEN_SET_OFF, $random(seed));
            verify();
        end
        $display("test random done");
        // a reset in mid-run must drop every enable that was set
        wr(`IEN_SET_OFF, 32'hFFFFFFFF);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        @(posedge clk_sys_i);
        chk("reset_enable", 32'h00000000, enable_o);
        chk("reset_rdata", 32'h00000000, prdata_o);
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        model = 32'h00000000;
        verify();
        $display("test mid reset done");
        xfer(1'b1, 12'h008, 32'hFFFFFFFF);
        chk("slverr", 32'h00000001, {31'h0, er});
        verify();
        xfer(1'b0, 12'h008, 32'h00000000);
        chk("unmapped_rd", 32'h00000000, rd);
        $display("test unmapped done");
        test_done();
    end
endmodule
